// >>> rtl/fhs_map.svh
// fhs_map.svh: constants of the fault and hiccup sequencer
// assumes sys_clk at 100 MHz; included by bare name
`ifndef FHS_MAP_SVH
`define FHS_MAP_SVH

// ----------------------------------------
// clock
// ----------------------------------------
`define FHS_CLK_MHZ       100
`define FHS_CLK_NS        10

// ----------------------------------------
// protection times
// ----------------------------------------
`define FHS_OCP_WIN_US    1500
`define FHS_CLAMP_WIN_US  1500
`define FHS_HICCUP_US     40000
`define FHS_UV_HICCUP_US  200000
`define FHS_FB_DLY_NS     5000
`define FHS_OVP_DLY_NS    90
`define FHS_FB_DLY_CYC    ((`FHS_FB_DLY_NS + `FHS_CLK_NS - 1) / `FHS_CLK_NS)
`define FHS_OVP_DLY_CYC   ((`FHS_OVP_DLY_NS + `FHS_CLK_NS - 1) / `FHS_CLK_NS)

// ----------------------------------------
// soft stop ramp, in clock cycles
// ----------------------------------------
`define FHS_MIN_PULSE     12'h014
`define FHS_STOP_STEP     12'h004

// ----------------------------------------
// reset values
// ----------------------------------------
`define FHS_CNT_RST       25'h0000000
`define FHS_WIDTH_RST     12'h000
`define FHS_DLY_RST       10'h000

`endif

// >>> rtl/fhs_pkg.sv
// fhs_pkg.sv: types of the fault and hiccup sequencer
// assumes nothing beyond a SystemVerilog tool
`default_nettype none

package fhs_pkg;

   typedef enum logic [2:0] {
      ST_OFF,
      ST_SOFTSTART,
      ST_RUN,
      ST_RECOVER,
      ST_SOFTSTOP,
      ST_HICCUP
   } fhs_state_e;

   typedef logic [24:0] fhs_cnt_t;
   typedef logic [11:0] fhs_width_t;
   typedef logic [9:0]  fhs_dly_t;

   // synchronous comparator and modulator inputs
   typedef struct packed {
      logic csTrip;
      logic errClamped;
      logic errAboveMax;
      logic fbBelowUv;
      logic fbUvClear;
      logic fbOv;
      logic fbOvClear;
      logic ovpOv;
      logic ovpOvClear;
      logic ssAboveFb;
      logic ssAtFb;
      logic ssDone;
      logic secUvlo;
      logic enable;
      logic periodStart;
      logic pwmReq;
      logic fwdReq;
      logic freeReq;
   } fhs_sense_s;

   typedef struct packed {
      logic mainSwitch;
      logic forwardRect;
      logic freewheelRect;
   } fhs_drive_s;

   typedef struct packed {
      logic ssCharge;
      logic ssFastSink;
      logic ssStopSink;
   } fhs_ref_s;

   typedef struct packed {
      fhs_state_e state;
      fhs_cnt_t   ocpCnt;
      fhs_cnt_t   clampCnt;
      fhs_cnt_t   hiccupCnt;
      logic       ocpActive;
      logic       tripSeen;
      logic       prevMiss;
      logic       pulseKilled;
      logic       longHiccup;
      fhs_drive_s drive;
      fhs_ref_s   ssRef;
      logic       errLinkEn;
      logic       supplyOkOut;
      logic       supplyOkOeN;
      logic       hiccupFlag;
   } fhs_core_s;

   typedef struct packed {
      fhs_width_t onCnt;
      fhs_width_t lastOn;
      fhs_width_t width;
      fhs_width_t phase;
      logic       done;
      logic       pulse;
   } fhs_ramp_s;

   typedef struct packed {
      fhs_dly_t cnt;
      logic     flag;
   } fhs_filt_s;

endpackage

`default_nettype wire

// >>> rtl/fhs_fault_filter.sv
// fhs_fault_filter.sv: delayed fault flag with hysteresis release
// assumes synchronous raw set and clear levels
`default_nettype none
`include "fhs_map.svh"

module fhs_fault_filter #(
   parameter fhs_pkg::fhs_dly_t DLY = 10'h001
) (
   input  wire logic sys_clk,
   input  wire logic rstn,
   input  wire logic clkEn,
   input  wire logic setRaw,
   input  wire logic clearRaw,
   output logic      fault
);

   fhs_pkg::fhs_filt_s q;
   fhs_pkg::fhs_filt_s d;

   // ----------------------------------------
   // set after delay, release on hysteresis
   // ----------------------------------------
   always_comb begin
      d = q;
      if (q.flag) begin
         if (clearRaw) begin
            d.flag = 1'b0;
         end
         d.cnt = `FHS_DLY_RST;
      end else if (setRaw) begin
         d.cnt = q.cnt + 10'h001;
         if (d.cnt >= DLY) begin
            d.flag = 1'b1;
         end
      end else begin
         d.cnt = `FHS_DLY_RST;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         q <= '0;
      end else if (clkEn) begin
         q <= d;
      end
   end

   assign fault = q.flag;

   AST_FLAG_HOLDS:
   assert property (@(posedge sys_clk) disable iff (!rstn)
      (q.flag && !clearRaw) |=> q.flag)
      else $error("fault flag released without hysteresis crossing");

endmodule // fhs_fault_filter

`default_nettype wire

// >>> rtl/fhs_stop_ramp.sv
// fhs_stop_ramp.sv: soft stop pulse width generator
// assumes a one-cycle period start pulse from the oscillator
`default_nettype none
`include "fhs_map.svh"

module fhs_stop_ramp (
   input  wire logic sys_clk,
   input  wire logic rstn,
   input  wire logic clkEn,
   input  wire logic active,
   input  wire logic periodStart,
   input  wire logic pwmReq,
   output logic      pulse,
   output logic      done
);

   fhs_pkg::fhs_ramp_s q;
   fhs_pkg::fhs_ramp_s d;

   // ----------------------------------------
   // measure on time, then step it down
   // ----------------------------------------
   always_comb begin
      d = q;
      if (q.phase != 12'hfff) begin
         d.phase = q.phase + 12'h001;
      end
      if (periodStart) begin
         d.phase = `FHS_WIDTH_RST;
      end
      if (!active) begin
         d.done = 1'b0;
         if (periodStart) begin
            d.lastOn = q.onCnt;
            d.onCnt = {11'h000, pwmReq};
         end else if (pwmReq && q.onCnt != 12'hfff) begin
            d.onCnt = q.onCnt + 12'h001;
         end
         d.width = d.lastOn;
      end else if (periodStart) begin
         if (q.width == `FHS_WIDTH_RST) begin
            d.done = 1'b1;
         end else if (q.width <= `FHS_MIN_PULSE) begin
            d.width = `FHS_WIDTH_RST;
         end else if (q.width > `FHS_MIN_PULSE + `FHS_STOP_STEP) begin
            d.width = q.width - `FHS_STOP_STEP;
         end else begin
            d.width = `FHS_MIN_PULSE;
         end
      end
      d.pulse = active && !d.done && (d.phase < d.width);
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         q <= '0;
      end else if (clkEn) begin
         q <= d;
      end
   end

   assign pulse = q.pulse;
   assign done  = q.done;

   AST_RAMP_DOWN:
   assert property (@(posedge sys_clk) disable iff (!rstn)
      (clkEn && active && periodStart && q.width > `FHS_MIN_PULSE)
      |=> (q.width < $past(q.width)))
      else $error("soft stop width did not step down");

endmodule // fhs_stop_ramp

`default_nettype wire

// >>> rtl/fhs_sequencer.sv
// fhs_sequencer.sv: protection and fault sequencing of the converter
// assumes all comparator inputs already synchronous to sys_clk
//
// Function
// - a peak current trip ends the running main switch pulse at once
// - trips every period for 1.5 ms start a 40 ms hiccup then soft start
// - a trip period followed by a clean one still counts as tripping
// - only two clean periods in a row reset the overcurrent counter
// - error level above its clamp over 1.5 ms starts a hiccup
// - clamp plus low feedback: fast sink reference to feedback, restart
// - during precharge start, reference far above feedback re-enters recovery
// - enable loss turns both rectifier drives off immediately
// - soft stop steps main duty down to minimum pulse, then zero
// - soft stop sinks the reference to zero at 1.5x start rate
// - secondary undervoltage stops error level transfer across barrier
// - supply ok output is released while any fault is present
// - overvoltage fault when feedback and overvoltage sense both exceed 1.36 V
// - undervoltage fault when feedback falls to 1.1 V
// - fault flag clears only after 36 mV hysteresis crossing
// - fault delay is 5 us for feedback, 90 ns for overvoltage
// - secondary undervoltage starts a 200 ms hiccup instead of 40 ms
`default_nettype none
`include "fhs_map.svh"

module fhs_sequencer #(
   parameter fhs_pkg::fhs_cnt_t OCP_WIN_CYC   = 25'(`FHS_OCP_WIN_US * `FHS_CLK_MHZ),
   parameter fhs_pkg::fhs_cnt_t CLAMP_WIN_CYC = 25'(`FHS_CLAMP_WIN_US * `FHS_CLK_MHZ),
   parameter fhs_pkg::fhs_cnt_t HICCUP_CYC    = 25'(`FHS_HICCUP_US * `FHS_CLK_MHZ),
   parameter fhs_pkg::fhs_cnt_t UV_HICCUP_CYC = 25'(`FHS_UV_HICCUP_US * `FHS_CLK_MHZ)
) (
   input  wire logic               sys_clk,
   input  wire logic               rstn,
   input  wire logic               clkEn,
   input  wire fhs_pkg::fhs_sense_s sense,
   output var  fhs_pkg::fhs_drive_s drive,
   output var  fhs_pkg::fhs_ref_s   ssRef,
   output logic                    errLinkEn,
   output logic                    supplyOkOut,
   output logic                    supplyOkOeN,
   output logic                    hiccupFlag
);

   fhs_pkg::fhs_core_s q;
   fhs_pkg::fhs_core_s d;

   logic [1:0] faultSet;
   logic [1:0] faultClr;
   logic [1:0] fault;
   logic       rampPulse;
   logic       rampDone;
   logic       rampActive;
   logic       live;
   logic       ocpHit;
   logic       clampHit;
   fhs_pkg::fhs_cnt_t hiccupLim;

   // ----------------------------------------
   // supply ok fault detectors
   // ----------------------------------------
   assign faultSet[0] = sense.fbBelowUv;
   assign faultClr[0] = sense.fbUvClear;
   assign faultSet[1] = sense.fbOv && sense.ovpOv;
   assign faultClr[1] = sense.fbOvClear && sense.ovpOvClear;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_fault
         localparam fhs_pkg::fhs_dly_t DLY =
            (gi == 0) ? 10'(`FHS_FB_DLY_CYC) : 10'(`FHS_OVP_DLY_CYC);
         fhs_fault_filter #(
            .DLY (DLY)
         ) u_filt (
            .sys_clk  (sys_clk),
            .rstn     (rstn),
            .clkEn    (clkEn),
            .setRaw   (faultSet[gi]),
            .clearRaw (faultClr[gi]),
            .fault    (fault[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // soft stop ramp
   // ----------------------------------------
   assign rampActive = (q.state == fhs_pkg::ST_SOFTSTOP);

   fhs_stop_ramp u_ramp (
      .sys_clk     (sys_clk),
      .rstn        (rstn),
      .clkEn       (clkEn),
      .active      (rampActive),
      .periodStart (sense.periodStart),
      .pwmReq      (sense.pwmReq),
      .pulse       (rampPulse),
      .done        (rampDone)
   );

   // ----------------------------------------
   // protection timers
   // ----------------------------------------
   assign live = (q.state == fhs_pkg::ST_SOFTSTART) ||
                 (q.state == fhs_pkg::ST_RUN) ||
                 (q.state == fhs_pkg::ST_RECOVER);
   assign ocpHit    = q.ocpCnt >= OCP_WIN_CYC;
   assign clampHit  = q.clampCnt > CLAMP_WIN_CYC;
   assign hiccupLim = q.longHiccup ? UV_HICCUP_CYC : HICCUP_CYC;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      d = q;
      // per period overcurrent bookkeeping
      if (sense.csTrip) begin
         d.tripSeen = 1'b1;
      end
      if (sense.periodStart) begin
         d.tripSeen = sense.csTrip;
         if (q.tripSeen) begin
            d.ocpActive = 1'b1;
            d.prevMiss  = 1'b0;
         end else if (q.prevMiss) begin
            d.ocpActive = 1'b0;
         end else begin
            d.prevMiss = 1'b1;
         end
      end
      if (live && d.ocpActive) begin
         d.ocpCnt = q.ocpCnt + 25'h0000001;
      end else begin
         d.ocpCnt = `FHS_CNT_RST;
      end
      if (live && sense.errAboveMax) begin
         d.clampCnt = q.clampCnt + 25'h0000001;
      end else begin
         d.clampCnt = `FHS_CNT_RST;
      end
      d.pulseKilled = !sense.periodStart && (q.pulseKilled || sense.csTrip);
      d.hiccupCnt = `FHS_CNT_RST;

      unique case (q.state)
         fhs_pkg::ST_OFF: begin
            if (sense.enable && !sense.secUvlo) begin
               d.state = fhs_pkg::ST_SOFTSTART;
            end
         end
         fhs_pkg::ST_SOFTSTART,
         fhs_pkg::ST_RUN,
         fhs_pkg::ST_RECOVER: begin
            if (!sense.enable) begin
               d.state = fhs_pkg::ST_SOFTSTOP;
            end else if (sense.secUvlo) begin
               d.state = fhs_pkg::ST_HICCUP;
               d.longHiccup = 1'b1;
            end else if (ocpHit || clampHit) begin
               d.state = fhs_pkg::ST_HICCUP;
               d.longHiccup = 1'b0;
            end else if (q.state == fhs_pkg::ST_SOFTSTART) begin
               if (sense.ssAboveFb && sense.errClamped) begin
                  d.state = fhs_pkg::ST_RECOVER;
               end else if (sense.ssDone) begin
                  d.state = fhs_pkg::ST_RUN;
               end
            end else if (q.state == fhs_pkg::ST_RUN) begin
               if (sense.errClamped && sense.fbBelowUv) begin
                  d.state = fhs_pkg::ST_RECOVER;
               end
            end else if (sense.ssAtFb) begin
               d.state = fhs_pkg::ST_SOFTSTART;
            end
         end
         fhs_pkg::ST_SOFTSTOP: begin
            if (rampDone) begin
               d.state = fhs_pkg::ST_OFF;
            end
         end
         fhs_pkg::ST_HICCUP: begin
            d.hiccupCnt = q.hiccupCnt + 25'h0000001;
            if (q.hiccupCnt >= hiccupLim - 25'h0000001) begin
               d.hiccupCnt  = `FHS_CNT_RST;
               d.ocpActive  = 1'b0;
               d.prevMiss   = 1'b0;
               d.tripSeen   = 1'b0;
               d.longHiccup = 1'b0;
               d.state = sense.enable ? fhs_pkg::ST_SOFTSTART : fhs_pkg::ST_OFF;
            end
         end
         default: begin
            d.state = fhs_pkg::ST_OFF;
         end
      endcase

      if (d.state == fhs_pkg::ST_HICCUP) begin
         d.ocpActive = 1'b0;
         d.ocpCnt    = `FHS_CNT_RST;
         d.clampCnt  = `FHS_CNT_RST;
      end

      // drives follow the next state
      d.drive = '0;
      unique case (d.state)
         fhs_pkg::ST_SOFTSTART,
         fhs_pkg::ST_RUN,
         fhs_pkg::ST_RECOVER: begin
            d.drive.mainSwitch = sense.pwmReq && !sense.csTrip &&
                                 !(q.pulseKilled && !sense.periodStart);
            d.drive.forwardRect   = sense.fwdReq;
            d.drive.freewheelRect = sense.freeReq;
         end
         fhs_pkg::ST_SOFTSTOP: begin
            d.drive.mainSwitch = rampPulse && !sense.csTrip &&
                                 !(q.pulseKilled && !sense.periodStart);
         end
         default: begin
            d.drive = '0;
         end
      endcase

      d.ssRef.ssCharge   = (d.state == fhs_pkg::ST_SOFTSTART);
      d.ssRef.ssFastSink = (d.state == fhs_pkg::ST_RECOVER);
      d.ssRef.ssStopSink = (d.state == fhs_pkg::ST_SOFTSTOP);
      d.errLinkEn   = !sense.secUvlo;
      d.supplyOkOut = 1'b0;
      d.supplyOkOeN = !((d.state == fhs_pkg::ST_RUN) && (fault == 2'b00));
      d.hiccupFlag  = (d.state == fhs_pkg::ST_HICCUP);
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         q <= '{state: fhs_pkg::ST_OFF, supplyOkOeN: 1'b1, default: '0};
      end else if (clkEn) begin
         q <= d;
      end
   end

   assign drive       = q.drive;
   assign ssRef       = q.ssRef;
   assign errLinkEn   = q.errLinkEn;
   assign supplyOkOut = q.supplyOkOut;
   assign supplyOkOeN = q.supplyOkOeN;
   assign hiccupFlag  = q.hiccupFlag;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   AST_PULSE_KILL:
   assert property (clkEn && sense.csTrip |=> !drive.mainSwitch)
      else $error("main switch pulse not ended on current trip");

   AST_OCP_HICCUP:
   assert property (clkEn && live && ocpHit && sense.enable && !sense.secUvlo
      |=> (q.state == fhs_pkg::ST_HICCUP) && !q.longHiccup && hiccupFlag)
      else $error("overcurrent window did not start standard hiccup");

   AST_OCP_HOLD:
   assert property (clkEn && sense.periodStart && q.tripSeen
      && (d.state != fhs_pkg::ST_HICCUP) |=> q.ocpActive)
      else $error("trip period not held in overcurrent counter");

   AST_OCP_RESET:
   assert property (clkEn && sense.periodStart && !q.tripSeen && q.prevMiss
      |=> !q.ocpActive ##1 (q.ocpCnt == 25'h0000000 || !clkEn))
      else $error("two clean periods did not reset the counter");

   AST_SINGLE_MISS:
   assert property (clkEn && live && sense.periodStart && !q.tripSeen
      && !q.prevMiss && q.ocpActive && (d.state == q.state) |=> q.ocpActive)
      else $error("single clean period reset the counter");

   AST_CLAMP_HICCUP:
   assert property (clkEn && live && clampHit && sense.enable && !sense.secUvlo
      |=> q.state == fhs_pkg::ST_HICCUP)
      else $error("clamp timeout did not start hiccup");

   AST_RECOVER:
   assert property (clkEn && q.state == fhs_pkg::ST_RUN && sense.enable
      && !sense.secUvlo && !ocpHit && !clampHit
      && sense.errClamped && sense.fbBelowUv
      |=> (q.state == fhs_pkg::ST_RECOVER) && ssRef.ssFastSink && !ssRef.ssCharge)
      else $error("recovery not entered on clamp with low feedback");

   AST_REENTER:
   assert property (clkEn && q.state == fhs_pkg::ST_SOFTSTART && sense.enable
      && !sense.secUvlo && !ocpHit && !clampHit
      && sense.ssAboveFb && sense.errClamped
      |=> q.state == fhs_pkg::ST_RECOVER)
      else $error("recovery not re-entered during precharge start");

   AST_RECT_OFF:
   assert property (clkEn && !sense.enable
      |=> !drive.forwardRect && !drive.freewheelRect)
      else $error("rectifier drives still on after enable loss");

   AST_STOP_SINK:
   assert property (clkEn && live && !sense.enable
      |=> ssRef.ssStopSink && !ssRef.ssCharge && !ssRef.ssFastSink)
      else $error("soft stop sink not applied");

   AST_LINK_OFF:
   assert property (clkEn && sense.secUvlo |=> !errLinkEn)
      else $error("error level transfer during secondary undervoltage");

   AST_FAULT_RELEASE:
   assert property (clkEn && (fault != 2'b00) |=> supplyOkOeN)
      else $error("supply ok held low during fault");

   AST_OVP_DELAY:
   assert property (clkEn && !fault[1] && faultSet[1] ##1 (clkEn && faultSet[1])[*8]
      |=> fault[1] ##1 supplyOkOeN)
      else $error("overvoltage fault not flagged after its delay");

   AST_UV_HICCUP:
   assert property (clkEn && live && sense.enable && sense.secUvlo
      |=> (q.state == fhs_pkg::ST_HICCUP) && q.longHiccup)
      else $error("secondary undervoltage did not start long hiccup");

   AST_HICCUP_CLEAR:
   assert property ($rose(q.state == fhs_pkg::ST_HICCUP)
      |-> (q.ocpCnt == 25'h0000000) && !q.ocpActive && !drive.mainSwitch)
      else $error("protection counters not cleared in hiccup");

endmodule // fhs_sequencer

`default_nettype wire

// >>> verification/fhs_plant.sv
// fhs_plant.sv: oscillator period pulses and flag pin pull-up around the sequencer
// assumes the bench clock; the flag pin is pulled up when released
`default_nettype none

module fhs_plant #(
   parameter int PER = 40
) (
   input  wire logic sys_clk,
   input  wire logic rstn,
   input  wire logic okOeN,
   input  wire logic okOut,
   output var  logic periodStart,
   output wire logic okPin
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // switching period
   // ----------------------------------------
   int n = 0;

   // one cycle pulse per period; reference left alone, no tracking or shutdown pull
   always @(negedge sys_clk) begin
      n = (!rstn || n == PER - 1) ? 0 : n + 1;
      periodStart <= rstn && n == 0;
   end

   // ----------------------------------------
   // open-drain flag pin
   // ----------------------------------------
   assign okPin = okOeN ? 1'b1 : okOut;
endmodule // fhs_plant

`default_nettype wire

// >>> verification/fhs_sequencer_test.sv
// fhs_sequencer_test.sv: self-checking bench of the fault and hiccup sequencer
// assumes fhs_plant for period pulses and the flag pull-up; short protection windows
`default_nettype none
`include "fhs_map.svh"

module fhs_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic                sys_clk    = 1'b0;
   logic                rstn       = 1'b0;
   logic                clkEn      = 1'b1;
   fhs_pkg::fhs_sense_s s          = '0;
   fhs_pkg::fhs_sense_s sIn;
   fhs_pkg::fhs_drive_s drive;
   fhs_pkg::fhs_ref_s   ssRef;
   logic                errLinkEn, okOut, okOeN, hic, perStart, okPin;
   int                  n_mismatch = 0;
   int                  checked    = 0;

   always_comb begin
      sIn = s;
      sIn.periodStart = perStart;
   end

   fhs_sequencer #(.OCP_WIN_CYC(25'h00000c8), .CLAMP_WIN_CYC(25'h0000028), .HICCUP_CYC(25'h0000064),
      .UV_HICCUP_CYC(25'h000012c)) dut (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .sense(sIn),
      .drive(drive), .ssRef(ssRef), .errLinkEn(errLinkEn), .supplyOkOut(okOut), .supplyOkOeN(okOeN),
      .hiccupFlag(hic));
   fhs_plant #(.PER(40)) plant (.sys_clk(sys_clk), .rstn(rstn), .okOeN(okOeN), .okOut(okOut),
      .periodStart(perStart), .okPin(okPin));

   initial forever #5 sys_clk = ~sys_clk;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic cyc(int k);
      repeat (k) @(negedge sys_clk);
   endtask

   task automatic chk(string nm, logic e, logic g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic up;
      for (int i = 0; i < 400 && hic !== 1'b0; i++) cyc(1);
      s.ssDone = 1'b1;
      cyc(2);
      s.ssDone = 1'b0;
      cyc(1);
   endtask

   task automatic finish_test;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_start;
      cyc(8);
      chk("flag pin", 1'b1, okPin);
      chk("hiccup", 1'b0, hic);
      rstn = 1'b1;
      s.enable = 1'b1;
      cyc(2);
      chk("charge", 1'b1, ssRef.ssCharge);
      chk("flag pin", 1'b1, okPin);
      up();
      s.pwmReq = 1'b1;
      s.fwdReq = 1'b1;
      s.freeReq = 1'b1;
      cyc(2);
      chk("flag pin", 1'b0, okPin);
      chk("link", 1'b1, errLinkEn);
      chk("forward", 1'b1, drive.forwardRect);
   endtask

   task automatic t_trip;
      for (int i = 0; i < 50 && !perStart; i++) cyc(1);
      cyc(3);
      chk("main", 1'b1, drive.mainSwitch);
      s.csTrip = 1'b1;
      cyc(1);
      chk("main", 1'b0, drive.mainSwitch);
      s.csTrip = 1'b0;
      cyc(3);
      chk("main", 1'b0, drive.mainSwitch);
      cyc(300);
      chk("hiccup", 1'b0, hic);
   endtask

   task automatic t_ocp;
      int p = 0;
      for (int i = 0; i < 400 && hic !== 1'b1; i++) begin
         cyc(1);
         s.csTrip = perStart && !p[0];
         if (perStart) p++;
      end
      s.csTrip = 1'b0;
      chk("hiccup", 1'b1, hic);
      cyc(1);
      chk("main", 1'b0, drive.mainSwitch);
      cyc(90);
      chk("hiccup", 1'b1, hic);
      cyc(20);
      chk("hiccup", 1'b0, hic);
      chk("charge", 1'b1, ssRef.ssCharge);
      up();
      cyc(250);
      chk("hiccup", 1'b0, hic);
   endtask

   task automatic t_clamp;
      s.errAboveMax = 1'b1;
      cyc(38);
      chk("hiccup", 1'b0, hic);
      cyc(6);
      chk("hiccup", 1'b1, hic);
      s.errAboveMax = 1'b0;
      up();
   endtask

   task automatic t_recov;
      s.errClamped = 1'b1;
      s.fbBelowUv = 1'b1;
      cyc(2);
      chk("fast sink", 1'b1, ssRef.ssFastSink);
      s.errClamped = 1'b0;
      s.fbBelowUv = 1'b0;
      s.ssAtFb = 1'b1;
      cyc(2);
      s.ssAtFb = 1'b0;
      chk("charge", 1'b1, ssRef.ssCharge);
      s.ssAboveFb = 1'b1;
      s.errClamped = 1'b1;
      cyc(2);
      chk("fast sink", 1'b1, ssRef.ssFastSink);
      s.ssAboveFb = 1'b0;
      s.errClamped = 1'b0;
      s.ssAtFb = 1'b1;
      cyc(2);
      s.ssAtFb = 1'b0;
      up();
   endtask

   task automatic t_freeze;
      clkEn = 1'b0;
      s.secUvlo = 1'b1;
      cyc(5);
      chk("hiccup", 1'b0, hic);
      chk("link", 1'b1, errLinkEn);
      chk("flag pin", 1'b0, okPin);
      s.secUvlo = 1'b0;
      clkEn = 1'b1;
      cyc(2);
      chk("hiccup", 1'b0, hic);
      chk("flag pin", 1'b0, okPin);
   endtask

   task automatic t_good;
      s.fbBelowUv = 1'b1;
      cyc(480);
      chk("flag pin", 1'b0, okPin);
      cyc(30);
      chk("flag pin", 1'b1, okPin);
      s.fbBelowUv = 1'b0;
      cyc(5);
      chk("flag pin", 1'b1, okPin);
      s.fbUvClear = 1'b1;
      cyc(3);
      chk("flag pin", 1'b0, okPin);
      s.fbUvClear = 1'b0;
      s.fbOv = 1'b1;
      cyc(20);
      chk("flag pin", 1'b0, okPin);
      s.ovpOv = 1'b1;
      cyc(5);
      chk("flag pin", 1'b0, okPin);
      cyc(8);
      chk("flag pin", 1'b1, okPin);
      s.fbOv = 1'b0;
      s.ovpOv = 1'b0;
      s.fbOvClear = 1'b1;
      cyc(3);
      chk("flag pin", 1'b1, okPin);
      s.ovpOvClear = 1'b1;
      cyc(3);
      chk("flag pin", 1'b0, okPin);
      s.fbOvClear = 1'b0;
      s.ovpOvClear = 1'b0;
   endtask

   task automatic t_uv;
      s.secUvlo = 1'b1;
      cyc(2);
      chk("link", 1'b0, errLinkEn);
      chk("hiccup", 1'b1, hic);
      s.secUvlo = 1'b0;
      cyc(250);
      chk("hiccup", 1'b1, hic);
      cyc(60);
      chk("hiccup", 1'b0, hic);
      chk("link", 1'b1, errLinkEn);
      up();
   endtask

   task automatic t_stop;
      int   w    = 0;
      int   prev = 4096;
      int   bad  = 0;
      int   k    = 0;
      logic minSeen = 1'b0;
      logic last0   = 1'b0;
      cyc(90);
      s.enable = 1'b0;
      cyc(2);
      chk("forward", 1'b0, drive.forwardRect);
      chk("freewheel", 1'b0, drive.freewheelRect);
      chk("stop sink", 1'b1, ssRef.ssStopSink);
      for (int i = 0; i < 480; i++) begin
         cyc(1);
         w += int'(drive.mainSwitch);
         if (perStart) begin
            if (k > 0 && w > prev) bad++;
            if (k > 0) prev = w;
            if (w == `FHS_MIN_PULSE) minSeen = 1'b1;
            last0 = (w == 0);
            k++;
            w = 0;
         end
      end
      chk("steps down", 1'b1, bad == 0);
      chk("minimum pulse", 1'b1, minSeen);
      chk("final zero", 1'b1, last0);
      chk("stop sink", 1'b0, ssRef.ssStopSink);
      chk("flag pin", 1'b1, okPin);
   endtask

   // ----------------------------------------
   // sequence and watchdog
   // ----------------------------------------
   initial begin
      @(negedge sys_clk);
      t_start();
      t_trip();
      t_ocp();
      t_clamp();
      t_recov();
      t_freeze();
      t_good();
      t_uv();
      t_stop();
      finish_test();
   end

   initial begin
      #200us;
      n_mismatch++;
      finish_test();
   end
endmodule // fhs_sequencer_test

`default_nettype wire
